// File: verif/spl_host_model.sv
// Purpose: Host driving the pulse control pin
// Assumes: Tasks are entered on a rising mclk edge
// Notes:   Widths in mclk cycles, scaled like the receiver parameters
`timescale 1ns/1ps
module spl_host_model (
  input  wire logic mclk,
  output logic      pin
);
  initial pin = 1'b0;
  task automatic level(input logic v, input int n);
    pin <= v;
    repeat (n) @(posedge mclk);
  endtask
  // Pulse width w stays far below the hold window so no pulse reads as a hold
  task automatic field(input int cnt, input int w, input int hold);
    for (int i = 0; i < cnt; i++) begin
      level(1'b0, w);
      level(1'b1, w);
    end
    level(1'b1, hold);
  endtask
endmodule // spl_host_model

// File: verif/spl_pulse_link_asserts.sv
// Purpose: Port assertions for the pulse link receiver
// Assumes: Counters watch the raw pin, so bounds leave room for the sync flops
// Notes:   Bound to every spl_pulse_link instance
`timescale 1ns/1ps
`include "spl_defines.svh"
module spl_pulse_link_chk #(
  parameter int SETTLE_CYC = 40, HOLD_MIN_CYC = 20, STANDBY_CYC = 100,
  parameter int BUS_RESET_CYC = 120, SHUTDOWN_CYC = 100
) (
  input wire logic mclk, arst_n, pulseControlPin, deviceEnable, sleepMode, busStandby,
  input wire logic busResetPulse,
  input wire logic [`SPL_FIELD_W-1:0] ledEnable, bankCurrentA, bankCurrentB, bankCurrentC,
  input wire logic [`SPL_FIELD_W-1:0] bankGroup
);
  logic [15:0] hiCnt, loCnt;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hiCnt <= '0;
      loCnt <= '0;
    end else begin
      hiCnt <= pulseControlPin ? hiCnt + 16'h1 : 16'h0;
      loCnt <= pulseControlPin ? 16'h0 : loCnt + 16'h1;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  property p_latch(logic [5:0] r);
    $changed(r) && $past(deviceEnable) && deviceEnable |-> hiCnt >= HOLD_MIN_CYC;
  endproperty
  enable_settle_a: assert property ($rose(deviceEnable) |-> hiCnt >= SETTLE_CYC)
    else $error("enable too early");
  enable_due_a: assert property (hiCnt == SETTLE_CYC + 8 |-> deviceEnable)
    else $error("enable missing");
  shutdown_min_a: assert property ($fell(deviceEnable) |-> loCnt >= SHUTDOWN_CYC)
    else $error("shutdown too early");
  shutdown_due_a: assert property (loCnt == SHUTDOWN_CYC + 8 |-> !deviceEnable)
    else $error("shutdown missing");
  off_clears_a: assert property (!deviceEnable [*2] |->
    {ledEnable, bankCurrentA, bankCurrentB, bankCurrentC, bankGroup} == '0)
    else $error("registers kept while off");
  bus_reset_a: assert property (busResetPulse |->
    hiCnt >= BUS_RESET_CYC ##1 !busResetPulse) else $error("bad bus reset pulse");
  bus_reset_due_a: assert property (deviceEnable && hiCnt == BUS_RESET_CYC + 3 |->
    busResetPulse) else $error("bus reset pulse missing");
  standby_min_a: assert property ($rose(busStandby) |-> hiCnt >= STANDBY_CYC)
    else $error("standby too early");
  sleep_sinks_a: assert property (|ledEnable |-> !sleepMode)
    else $error("sleep with sinks on");
  led_latch_a: assert property (p_latch(ledEnable))
    else $error("led write without hold");
  group_latch_a: assert property (p_latch(bankGroup))
    else $error("group write without hold");
  cover property ($rose(busStandby));
  cover property ($fell(deviceEnable));
  cover property ($changed(bankGroup));
endmodule // spl_pulse_link_chk
bind spl_pulse_link spl_pulse_link_chk #(.SETTLE_CYC(SETTLE_CYC),
  .HOLD_MIN_CYC(HOLD_MIN_CYC), .STANDBY_CYC(STANDBY_CYC),
  .BUS_RESET_CYC(BUS_RESET_CYC), .SHUTDOWN_CYC(SHUTDOWN_CYC)) u_chk (.*);

// File: verif/spl_pulse_link_bench.sv
// Purpose: Self-checking bench for the pulse link receiver
// Assumes: Scaled counts 40,20,100,120,100; first-hold ceiling left at its default
// Notes:   Host model owns the pin
`timescale 1ns/1ps
`include "spl_defines.svh"
module spl_pulse_link_bench;
  logic mclk = 1'b0, arst_n = 1'b0, pin;
  logic deviceEnable, sleepMode, busStandby, busResetPulse;
  logic [`SPL_FIELD_W-1:0] ledEnable, bankCurrentA, bankCurrentB, bankCurrentC, bankGroup;
  int nFail = 0, checksDone = 0, cycles = 0;
  always #5 mclk = ~mclk;
  spl_host_model u_host (.mclk(mclk), .pin(pin));
  spl_pulse_link #(.SETTLE_CYC(40), .HOLD_MIN_CYC(20),
    .STANDBY_CYC(100), .BUS_RESET_CYC(120), .SHUTDOWN_CYC(100)) u_dut (.mclk(mclk),
    .arst_n(arst_n), .pulseControlPin(pin), .deviceEnable(deviceEnable),
    .sleepMode(sleepMode), .busStandby(busStandby), .busResetPulse(busResetPulse),
    .ledEnable(ledEnable), .bankCurrentA(bankCurrentA), .bankCurrentB(bankCurrentB),
    .bankCurrentC(bankCurrentC), .bankGroup(bankGroup));
  task automatic chk(input string what, input logic [5:0] seen, input logic [5:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nFail++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic closeOut();
    $display("checks %0d, mismatches %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic t_enable();
    u_host.level(1'b1, 30);
    chk("enable early", 6'(deviceEnable), 6'h00);
    u_host.level(1'b1, 20);
    chk("enable", 6'(deviceEnable), 6'h01);
    chk("sleep", 6'(sleepMode), 6'h01);
  endtask
  task automatic t_writes();
    for (int a = 1; a <= 5; a++) begin
      u_host.field(a, 2, 30);
      u_host.field(a + 6, a, 30);
    end
    chk("led", ledEnable, 6'h07);
    chk("bank a", bankCurrentA, 6'h08);
    chk("bank b", bankCurrentB, 6'h09);
    chk("bank c", bankCurrentC, 6'h0A);
    chk("group", bankGroup, 6'h0B);
    chk("sleep off", 6'(sleepMode), 6'h00);
  endtask
  task automatic t_bus_reset();
    u_host.field(2, 2, 105);
    chk("standby", 6'(busStandby), 6'h01);
    u_host.level(1'b1, 25);
    u_host.field(4, 2, 30);
    u_host.field(3, 2, 30);
    chk("partial dropped", bankCurrentA, 6'h08);
    chk("bank c new", bankCurrentC, 6'h03);
  endtask
  task automatic t_shutdown();
    u_host.level(1'b0, 90);
    chk("still on", 6'(deviceEnable), 6'h01);
    u_host.level(1'b0, 20);
    chk("off", 6'(deviceEnable), 6'h00);
    chk("led cleared", ledEnable, 6'h00);
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    t_enable();
    t_writes();
    t_bus_reset();
    t_shutdown();
    t_enable();
    closeOut();
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      nFail++;
      closeOut();
    end
  end
endmodule // spl_pulse_link_bench

// File: verilog/spl_defines.svh
// Purpose: Constants for the single-wire pulse link receiver
// Assumes: 100 MHz mclk
// Notes:   Times kept in their printed units; counts derived in the module
`ifndef SPL_DEFINES_SVH
`define SPL_DEFINES_SVH

`define SPL_CLK_MHZ          100
`define SPL_SETTLE_US        1000
`define SPL_HOLD_MIN_US      550
`define SPL_HOLD_FIRST_MAX_US 5000
`define SPL_STANDBY_US       10000
`define SPL_BUS_RESET_US     12000
`define SPL_SHUTDOWN_US      10000

`define SPL_CNT_W            21
`define SPL_FIELD_W          6
`define SPL_REG_AW           3

`define SPL_ADR_LED_EN       3'h1
`define SPL_ADR_BANK_A       3'h2
`define SPL_ADR_BANK_B       3'h3
`define SPL_ADR_BANK_C       3'h4
`define SPL_ADR_GROUP        3'h5

`endif

// File: verilog/spl_pkg.sv
// Purpose: Types for the single-wire pulse link receiver
// Assumes: Nothing beyond the defines header
// Notes:   States are one-hot
package spl_pkg;
  typedef enum logic [4:0] {
    ST_OFF     = 5'h01,
    ST_FIRST   = 5'h02,
    ST_SECOND  = 5'h04,
    ST_STANDBY = 5'h08,
    ST_SPARE   = 5'h10
  } spl_state_e;
endpackage

// File: verilog/spl_pulse_link.sv
// Purpose: Receiver for the single-wire pulse control pin: enable, shutdown,
//          field latching by high holds, bus reset, standby, register writes
// Assumes: pulseControlPin is asynchronous; one clock mclk
// Notes:   Pulse width limits are the host's duty and are not checked here
`timescale 1ns/1ps
`include "spl_defines.svh"

module spl_pulse_link
  import spl_pkg::*;
#(
  parameter int SETTLE_CYC     = `SPL_CLK_MHZ * `SPL_SETTLE_US,
  parameter int HOLD_MIN_CYC   = `SPL_CLK_MHZ * `SPL_HOLD_MIN_US,
  parameter int HOLD_MAX_CYC   = `SPL_CLK_MHZ * `SPL_HOLD_FIRST_MAX_US,
  parameter int STANDBY_CYC    = `SPL_CLK_MHZ * `SPL_STANDBY_US,
  parameter int BUS_RESET_CYC  = `SPL_CLK_MHZ * `SPL_BUS_RESET_US,
  parameter int SHUTDOWN_CYC   = `SPL_CLK_MHZ * `SPL_SHUTDOWN_US
) (
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      arst_n,
  // Control pin
  input  wire logic                      pulseControlPin,
  // Device state
  output logic                           deviceEnable,
  output logic                           sleepMode,
  output logic                           busStandby,
  output logic                           busResetPulse,
  // Configuration
  output logic [`SPL_FIELD_W-1:0]        ledEnable,
  output logic [`SPL_FIELD_W-1:0]        bankCurrentA,
  output logic [`SPL_FIELD_W-1:0]        bankCurrentB,
  output logic [`SPL_FIELD_W-1:0]        bankCurrentC,
  output logic [`SPL_FIELD_W-1:0]        bankGroup
);

  localparam int NREG = 1 << `SPL_REG_AW;
  localparam logic [`SPL_CNT_W-1:0]   CNT_MAX     = '1;
  localparam logic [`SPL_CNT_W-1:0]   SETTLE_C    = SETTLE_CYC[`SPL_CNT_W-1:0];
  localparam logic [`SPL_CNT_W-1:0]   HOLD_MIN_C  = HOLD_MIN_CYC[`SPL_CNT_W-1:0];
  localparam logic [`SPL_CNT_W-1:0]   HOLD_MAX_C  = HOLD_MAX_CYC[`SPL_CNT_W-1:0];
  localparam logic [`SPL_CNT_W-1:0]   STANDBY_C   = STANDBY_CYC[`SPL_CNT_W-1:0];
  localparam logic [`SPL_CNT_W-1:0]   BUS_RESET_C = BUS_RESET_CYC[`SPL_CNT_W-1:0];
  localparam logic [`SPL_CNT_W-1:0]   SHUTDOWN_C  = SHUTDOWN_CYC[`SPL_CNT_W-1:0];
  localparam logic [`SPL_FIELD_W-1:0] NREG_F      = NREG[`SPL_FIELD_W-1:0];
  localparam logic [`SPL_FIELD_W-1:0] ONE_PULSE   = {{(`SPL_FIELD_W-1){1'b0}}, 1'b1};

  // Synchroniser; first stage feeds only the second
  logic                    pinMeta_r, pinSync_r, pinPrev_r;
  logic [`SPL_CNT_W-1:0]   highCnt_r, highCnt_nxt;
  logic [`SPL_CNT_W-1:0]   lowCnt_r, lowCnt_nxt;
  logic                    rise;
  logic                    highSettle, highHold, highOver;
  logic                    highStandby, highBusReset, lowShutdown;

  // Receiver state
  logic [`SPL_FIELD_W-1:0] pulseCnt_r, pulseCnt_nxt;
  logic [`SPL_FIELD_W-1:0] addr_r, addr_nxt;
  spl_state_e              state_r, state_nxt;
  logic                    busReset_nxt;
  logic                    wrStrobe, clearAll;

  // Register file
  logic [`SPL_FIELD_W-1:0] regs_r [NREG];
  logic [`SPL_FIELD_W-1:0] regs_nxt [NREG];

  // Status outputs
  logic                    enable_nxt, sleep_nxt, standby_nxt;

  // Level counters saturate so a stuck pin cannot wrap into a false hold
  always_comb begin
    rise         = pinSync_r & ~pinPrev_r;
    highCnt_nxt  = !pinSync_r ? '0 : (highCnt_r == CNT_MAX ? highCnt_r : highCnt_r + 1'b1);
    lowCnt_nxt   = pinSync_r ? '0 : (lowCnt_r == CNT_MAX ? lowCnt_r : lowCnt_r + 1'b1);
    highSettle   = pinSync_r && (highCnt_r == SETTLE_C);
    highHold     = pinSync_r && (highCnt_r == HOLD_MIN_C);
    highOver     = (highCnt_r > HOLD_MAX_C);
    highStandby  = pinSync_r && (highCnt_r == STANDBY_C);
    highBusReset = pinSync_r && (highCnt_r == BUS_RESET_C);
    lowShutdown  = !pinSync_r && (lowCnt_r == SHUTDOWN_C);
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pinMeta_r <= 1'b0;
      pinSync_r <= 1'b0;
      pinPrev_r <= 1'b0;
      highCnt_r <= '0;
      lowCnt_r  <= '0;
    end else begin
      pinMeta_r <= pulseControlPin;
      pinSync_r <= pinMeta_r;
      pinPrev_r <= pinSync_r;
      highCnt_r <= highCnt_nxt;
      lowCnt_r  <= lowCnt_nxt;
    end
  end

  // Field decoding: pulses counted, a long high latches the count
  always_comb begin
    state_nxt    = state_r;
    pulseCnt_nxt = pulseCnt_r;
    addr_nxt     = addr_r;
    busReset_nxt = 1'b0;
    wrStrobe     = 1'b0;
    clearAll     = 1'b0;
    // Count rising pulses, saturating so a long burst cannot wrap to a small value
    if (rise && pulseCnt_r != '1) begin
      pulseCnt_nxt = pulseCnt_r + 1'b1;
    end
    case (state_r)
      ST_OFF: begin
        pulseCnt_nxt = '0;
        if (highSettle) begin
          state_nxt = ST_FIRST;
        end
      end
      ST_FIRST: begin
        if (highHold && pulseCnt_r != '0) begin
          addr_nxt     = pulseCnt_r;
          pulseCnt_nxt = '0;
          state_nxt    = ST_SECOND;
        end
      end
      ST_SECOND: begin
        if (highHold && pulseCnt_r != '0) begin
          // Addresses beyond the file are accepted on the wire but dropped
          if (addr_r < NREG_F) begin
            wrStrobe = 1'b1;
          end
          pulseCnt_nxt = '0;
          state_nxt    = ST_FIRST;
        end else if (pulseCnt_r == '0 && highOver) begin
          // First hold overran its window: the latched address is not trusted
          addr_nxt  = '0;
          state_nxt = ST_FIRST;
        end
      end
      ST_STANDBY: begin
        if (rise) begin
          pulseCnt_nxt = ONE_PULSE;
          state_nxt    = ST_FIRST;
        end
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
    if (state_r != ST_OFF) begin
      if (highStandby) begin
        state_nxt    = ST_STANDBY;
        pulseCnt_nxt = '0;
      end
      if (highBusReset) begin
        busReset_nxt = 1'b1;
        pulseCnt_nxt = '0;
        addr_nxt     = '0;
        state_nxt    = ST_STANDBY;
      end
      if (lowShutdown) begin
        state_nxt    = ST_OFF;
        pulseCnt_nxt = '0;
        addr_nxt     = '0;
        clearAll     = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pulseCnt_r <= '0;
      addr_r     <= '0;
      state_r    <= ST_OFF;
    end else begin
      pulseCnt_r <= pulseCnt_nxt;
      addr_r     <= addr_nxt;
      state_r    <= state_nxt;
    end
  end

  // One slot per address; shutdown clears every slot at once
  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_reg
      localparam logic [`SPL_REG_AW-1:0] SLOT = `SPL_REG_AW'(g);
      always_comb begin
        regs_nxt[g] = regs_r[g];
        if (clearAll) begin
          regs_nxt[g] = '0;
        end else if (wrStrobe && addr_r[`SPL_REG_AW-1:0] == SLOT) begin
          regs_nxt[g] = pulseCnt_r;
        end
      end
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          regs_r[g] <= '0;
        end else begin
          regs_r[g] <= regs_nxt[g];
        end
      end
    end
  endgenerate

  // Status follows the next state so it lines up with the register outputs
  always_comb begin
    enable_nxt  = (state_nxt != ST_OFF);
    standby_nxt = (state_nxt == ST_STANDBY);
    sleep_nxt   = enable_nxt && (regs_nxt[`SPL_ADR_LED_EN] == '0);
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      deviceEnable  <= 1'b0;
      sleepMode     <= 1'b0;
      busStandby    <= 1'b0;
      busResetPulse <= 1'b0;
    end else begin
      deviceEnable  <= enable_nxt;
      sleepMode     <= sleep_nxt;
      busStandby    <= standby_nxt;
      busResetPulse <= busReset_nxt;
    end
  end

  // Three banks each carry their own current code
  assign ledEnable    = regs_r[`SPL_ADR_LED_EN];
  assign bankCurrentA = regs_r[`SPL_ADR_BANK_A];
  assign bankCurrentB = regs_r[`SPL_ADR_BANK_B];
  assign bankCurrentC = regs_r[`SPL_ADR_BANK_C];
  assign bankGroup    = regs_r[`SPL_ADR_GROUP];

endmodule // spl_pulse_link
